// file: logic/fpsdt_map.vh
/*
 * Constants of the stack data-transfer block: register offsets,
 * field positions, reset values, operation and format codes, tags.
 * Assumes it is included by its bare name from the design file.
 */
`ifndef FPSDT_MAP_VH
`define FPSDT_MAP_VH
// ----------------------------------------------------------------
// register offsets and fields
// ----------------------------------------------------------------
`define FPSDT_REG_CTRL 2'h0
`define FPSDT_REG_TOP 2'h1
`define FPSDT_REG_TAG 2'h2
`define FPSDT_RC_LSB 0
`define FPSDT_CTRL_RST 2'h0
`define FPSDT_TOP_RST 3'h0
`define FPSDT_TAG_RST 16'hFFFF
// ----------------------------------------------------------------
// operation codes
// ----------------------------------------------------------------
`define FPSDT_OP_RLD 4'h0
`define FPSDT_OP_RST 4'h1
`define FPSDT_OP_RSTP 4'h2
`define FPSDT_OP_SWAP 4'h3
`define FPSDT_OP_ILD 4'h4
`define FPSDT_OP_IST 4'h5
`define FPSDT_OP_ISTP 4'h6
`define FPSDT_OP_DLD 4'h7
`define FPSDT_OP_DSTP 4'h8
// ----------------------------------------------------------------
// operand formats (real: short/long/temp/reg, int: word/short/long)
// ----------------------------------------------------------------
`define FPSDT_F_SHORT 2'h0
`define FPSDT_F_LONG 2'h1
`define FPSDT_F_TEMP 2'h2
`define FPSDT_F_REG 2'h3
`define FPSDT_F_IWORD 2'h0
`define FPSDT_F_ISHORT 2'h1
`define FPSDT_F_ILONG 2'h2
// ----------------------------------------------------------------
// tags and rounding modes
// ----------------------------------------------------------------
`define FPSDT_TAG_VALID 2'h0
`define FPSDT_TAG_ZERO 2'h1
`define FPSDT_TAG_SPEC 2'h2
`define FPSDT_TAG_EMPTY 2'h3
`define FPSDT_RC_NEAR 3'h0
`define FPSDT_RC_DOWN 3'h1
`define FPSDT_RC_UP 3'h2
`define FPSDT_RC_HALF 3'h4
// ----------------------------------------------------------------
// exponent constants
// ----------------------------------------------------------------
`define FPSDT_EXP_MAX 15'h7FFF
`define FPSDT_ADJ_SHORT 15'h3F80
`define FPSDT_ADJ_LONG 15'h3C00
`define FPSDT_EXP_INT 16'h403E
`define FPSDT_SH_SHORT 7'h28
`define FPSDT_SH_LONG 7'h0B
`endif

// file: logic/fpsdt_stack.v
/*
 * Eight-entry temporary-real register stack with its top pointer,
 * tag word and the data-transfer operations.
 * Assumes one clock, a synchronous active-low reset, a command
 * source on the same clock and a register master on the same clock.
 */
// Functional notes
// (RL1) real load decrements top, then copies source; reloading top duplicates
// (RL2) short and long real loads are converted to temporary real
// (RL3) real stores round significand by rounding field and rebias exponent
// (RL4) special tops are chopped, exponent chopped and copied unconverted
// (RL5) store-and-pop stores, tags top empty, then increments top
// (RL6) only the popping real store accepts temporary real destination
// (RL7) popping real store to top itself is a pure pop
// (RL8) swap exchanges top with named register, default one below top
// (RL9) integer load converts and pushes; tag zero if all bits zero
// (RL10) integer store rounds, word or short only; negative zero stored +0
// (RL11) popping integer store pops and also accepts long integers
// (RL12) decimal load is exact and keeps the sign, negative zero too
// (RL13) decimal digits above nine are not checked; result undefined
// (RL14) decimal store rounds by adding one half, chops, writes, pops
// (RL15) sources never change; conversion happens in scratch logic
// (RL16) every transfer leaves the tag word matching register contents
// (RL17) top pointer is three bits and wraps modulo eight
`include "fpsdt_map.vh"
module fpsdt_stack (
    // clock and reset
    input wire clk,
    input wire resetn,
    // register port
    input wire [1:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [15:0] reg_rdata,
    // command port
    input wire op_start,
    input wire [3:0] op_code,
    input wire [1:0] op_fmt,
    input wire [2:0] op_reg,
    input wire op_reg_given,
    input wire [79:0] mem_in,
    // results
    output reg op_done,
    output reg op_error,
    output reg mem_we,
    output reg [79:0] mem_out
);
// ----------------------------------------------------------------
// conversion functions
// ----------------------------------------------------------------
// right shift with rounding; carry out in bit 64
function [64:0] f_rnd;
    input [63:0] m;
    input [6:0] sh;
    input [2:0] mode;
    input s;
    reg [127:0] x;
    reg g, st, inc;
    begin
        x = {m, 64'h0} >> sh;
        g = x[63];
        st = |x[62:0];
        case (mode)
            `FPSDT_RC_NEAR: inc = g & (st | x[64]);
            `FPSDT_RC_DOWN: inc = s & (g | st);
            `FPSDT_RC_UP: inc = ~s & (g | st);
            `FPSDT_RC_HALF: inc = g;
            default: inc = 1'b0;
        endcase
        f_rnd = {1'b0, x[127:64]} + {64'h0, inc};
    end
endfunction
// normalise an integer magnitude into temporary real
function [79:0] f_norm;
    input s;
    input [63:0] mag;
    integer i;
    reg [6:0] cnt, lz;
    begin
        cnt = 7'h3F;
        lz = 7'h0;
        for (i = 0; i < 64; i = i + 1)
        begin
            if (mag[i])
                lz = cnt;
            cnt = cnt - 7'h1;
        end
        if (mag == 64'h0)
            f_norm = {s, 79'h0};
        else
            f_norm = {s, 15'h403E - {8'h0, lz}, mag << lz};
    end
endfunction
// tag from contents
function [1:0] f_tag;
    input [79:0] v;
    begin
        if (v[78:64] == `FPSDT_EXP_MAX)
            f_tag = `FPSDT_TAG_SPEC;
        else if (v[78:64] == 15'h0)
            f_tag = (v[63:0] == 64'h0) ? `FPSDT_TAG_ZERO : `FPSDT_TAG_SPEC;
        else
            f_tag = `FPSDT_TAG_VALID;
    end
endfunction
// short or long real to temporary real
function [79:0] f_ld;
    input [79:0] d;
    input [1:0] fmt;
    begin
        if (fmt == `FPSDT_F_SHORT)
        begin
            if (d[30:23] == 8'hFF)
                f_ld = {d[31], `FPSDT_EXP_MAX, 1'b1, d[22:0], 40'h0};
            else if (d[30:23] == 8'h0)
                f_ld = {d[31], 16'h0, d[22:0], 40'h0};
            else
                f_ld = {d[31], {7'h0, d[30:23]} + `FPSDT_ADJ_SHORT,
                        1'b1, d[22:0], 40'h0};
        end
        else if (fmt == `FPSDT_F_LONG)
        begin
            if (d[62:52] == 11'h7FF)
                f_ld = {d[63], `FPSDT_EXP_MAX, 1'b1, d[51:0], 11'h0};
            else if (d[62:52] == 11'h0)
                f_ld = {d[63], 16'h0, d[51:0], 11'h0};
            else
                f_ld = {d[63], {4'h0, d[62:52]} + `FPSDT_ADJ_LONG,
                        1'b1, d[51:0], 11'h0};
        end
        else
            f_ld = d;
    end
endfunction
// packed decimal digits to binary; digits above nine are not checked
function [63:0] f_dec;
    input [71:0] d;
    integer j;
    reg [63:0] acc;
    begin
        acc = 64'h0;
        for (j = 17; j >= 0; j = j - 1)
            acc = (acc << 3) + (acc << 1) + {60'h0, d[4*j +: 4]}; // RL13
        f_dec = acc;
    end
endfunction
// binary to eighteen packed decimal digits
function [71:0] f_bcd;
    input [63:0] b;
    integer i, j;
    reg [135:0] x;
    begin
        x = {72'h0, b};
        for (i = 0; i < 64; i = i + 1)
        begin
            for (j = 0; j < 18; j = j + 1)
                if (x[64+4*j +: 4] > 4'h4)
                    x[64+4*j +: 4] = x[64+4*j +: 4] + 4'h3;
            x = x << 1;
        end
        f_bcd = x[135:64];
    end
endfunction
// ----------------------------------------------------------------
// state
// ----------------------------------------------------------------
reg [79:0] stk [0:7];
reg [15:0] tagw;
reg [2:0] top;
reg [1:0] rc;
// ----------------------------------------------------------------
// scratch conversions; sources are only read here
// ----------------------------------------------------------------
wire [2:0] sel = op_reg_given ? op_reg : 3'h1;
wire [2:0] idx = top + op_reg; // RL17
wire [2:0] sidx = top + sel;
wire [2:0] dn = top - 3'h1;
wire [2:0] up = top + 3'h1;
wire [79:0] topv = stk[top];
wire [79:0] regv = stk[idx];
wire [79:0] swv = stk[sidx];
wire ts = topv[79];
wire [14:0] te = topv[78:64];
wire tspec = f_tag(topv) != `FPSDT_TAG_VALID; // zero chops to signed zero
reg [79:0] ld_val, st_real, st_int, st_dec;
reg [63:0] iv, mag, sval;
reg [64:0] rs, rl, ri;
reg [15:0] dsh;
reg [6:0] ish;
reg ovf;
// load value for each push flavour
always @*
begin
    case (op_fmt)
        `FPSDT_F_IWORD: iv = {{48{mem_in[15]}}, mem_in[15:0]};
        `FPSDT_F_ISHORT: iv = {{32{mem_in[31]}}, mem_in[31:0]};
        default: iv = mem_in[63:0];
    endcase
    mag = iv[63] ? (64'h0 - iv) : iv;
    case (op_code)
        `FPSDT_OP_RLD: ld_val = (op_fmt == `FPSDT_F_REG) ? regv
                                : f_ld(mem_in, op_fmt); // RL2
        `FPSDT_OP_ILD: ld_val = f_norm(iv[63], mag); // RL9
        default: ld_val = f_norm(mem_in[79], f_dec(mem_in[71:0])); // RL12
    endcase
end
// real store data
always @*
begin
    rs = f_rnd(topv[63:0], `FPSDT_SH_SHORT, {1'b0, rc}, ts);
    rl = f_rnd(topv[63:0], `FPSDT_SH_LONG, {1'b0, rc}, ts);
    st_real = topv;
    if (op_fmt == `FPSDT_F_SHORT)
    begin
        if (tspec)
            st_real = {48'h0, ts, te[14:7], topv[62:40]}; // RL4
        else
            st_real = {48'h0, ts,
                       te[7:0] - 8'h80 + {7'h0, rs[24]},
                       rs[22:0]}; // RL3
    end
    else if (op_fmt == `FPSDT_F_LONG)
    begin
        if (tspec)
            st_real = {16'h0, ts, te[14:4], topv[62:11]}; // RL4
        else
            st_real = {16'h0, ts,
                       te[10:0] - 11'h400 + {10'h0, rl[53]},
                       rl[51:0]}; // RL3
    end
end
// integer and decimal store data share one rounding shifter
always @*
begin
    dsh = `FPSDT_EXP_INT - {1'b0, te};
    ish = (dsh[15:7] != 9'h0) ? 7'h7F : dsh[6:0];
    ovf = dsh[15];
    ri = f_rnd(topv[63:0], ish,
               (op_code == `FPSDT_OP_DSTP) ? `FPSDT_RC_HALF
                                           : {1'b0, rc}, ts); // RL14
    ovf = ovf | ri[64];
    // a zero magnitude is never negated, so minus zero stores as +0
    sval = (ts && ri[63:0] != 64'h0) ? 64'h0 - ri[63:0]
                                    : ri[63:0]; // RL10
    case (op_fmt)
        `FPSDT_F_IWORD: st_int = {64'h0, ovf ? 16'h8000 : sval[15:0]};
        `FPSDT_F_ISHORT: st_int = {48'h0,
                                   ovf ? 32'h8000_0000 : sval[31:0]};
        default: st_int = {16'h0,
                           ovf ? 64'h8000_0000_0000_0000 : sval};
    endcase
    st_dec = {ts, 7'h0, f_bcd(ri[63:0])};
end
// ----------------------------------------------------------------
// operation sequencing, one command per cycle
// ----------------------------------------------------------------
integer k;
always @(posedge clk)
begin
    op_done <= 1'b0;
    op_error <= 1'b0;
    mem_we <= 1'b0;
    if (!resetn)
    begin
        for (k = 0; k < 8; k = k + 1)
            stk[k] <= 80'h0;
        tagw <= `FPSDT_TAG_RST;
        top <= `FPSDT_TOP_RST;
        mem_out <= 80'h0;
    end
    else if (op_start)
    begin
        op_done <= 1'b1;
        case (op_code)
            `FPSDT_OP_RLD, `FPSDT_OP_ILD, `FPSDT_OP_DLD:
            begin
                // source read above, before the pointer moves
                top <= dn; // RL1
                stk[dn] <= ld_val; // RL1
                tagw[{dn, 1'b0} +: 2] <= f_tag(ld_val); // RL16
            end
            `FPSDT_OP_RST, `FPSDT_OP_RSTP:
            begin
                if (op_code == `FPSDT_OP_RST
                    && op_fmt == `FPSDT_F_TEMP)
                    op_error <= 1'b1; // RL6
                else
                begin
                    if (op_fmt != `FPSDT_F_REG)
                    begin
                        mem_out <= st_real; // RL15
                        mem_we <= 1'b1;
                    end
                    else if (op_reg != 3'h0)
                    begin
                        stk[idx] <= topv;
                        tagw[{idx, 1'b0} +: 2] <=
                            tagw[{top, 1'b0} +: 2]; // RL16
                    end
                    if (op_code == `FPSDT_OP_RSTP)
                    begin
                        // index zero skips the copy: a bare pop
                        tagw[{top, 1'b0} +: 2] <= `FPSDT_TAG_EMPTY; // RL7
                        top <= up; // RL5
                    end
                end
            end
            `FPSDT_OP_SWAP:
            begin
                stk[top] <= swv; // RL8
                stk[sidx] <= topv;
                tagw[{top, 1'b0} +: 2] <= tagw[{sidx, 1'b0} +: 2];
                tagw[{sidx, 1'b0} +: 2] <= tagw[{top, 1'b0} +: 2];
            end
            `FPSDT_OP_IST, `FPSDT_OP_ISTP:
            begin
                if (op_fmt == `FPSDT_F_REG
                    || (op_code == `FPSDT_OP_IST
                        && op_fmt == `FPSDT_F_ILONG))
                    op_error <= 1'b1; // RL11
                else
                begin
                    mem_out <= st_int;
                    mem_we <= 1'b1;
                    if (op_code == `FPSDT_OP_ISTP)
                    begin
                        tagw[{top, 1'b0} +: 2] <= `FPSDT_TAG_EMPTY;
                        top <= up; // RL11
                    end
                end
            end
            `FPSDT_OP_DSTP:
            begin
                mem_out <= st_dec; // RL14
                mem_we <= 1'b1;
                tagw[{top, 1'b0} +: 2] <= `FPSDT_TAG_EMPTY;
                top <= up;
            end
            default: op_error <= 1'b1;
        endcase
    end
end
// ----------------------------------------------------------------
// register port
// ----------------------------------------------------------------
// rounding field is the only writable control
always @(posedge clk)
begin
    if (!resetn)
        rc <= `FPSDT_CTRL_RST;
    else if (reg_wr && reg_addr == `FPSDT_REG_CTRL)
        rc <= reg_wdata[`FPSDT_RC_LSB +: 2];
end
// read data stands one cycle after the strobe, zero otherwise
always @(posedge clk)
begin
    reg_rdata <= 16'h0;
    if (resetn && reg_rd)
        case (reg_addr)
            `FPSDT_REG_CTRL: reg_rdata <= {14'h0, rc};
            `FPSDT_REG_TOP: reg_rdata <= {13'h0, top};
            `FPSDT_REG_TAG: reg_rdata <= tagw;
            default: reg_rdata <= 16'h0;
        endcase
end
endmodule

// file: tb/fpsdt_stack_asserts.sv
/* checker for the stack data-transfer block, bound to its ports.
   assumes one clock and the synchronous active-low reset. */
`include "fpsdt_map.vh"
module fpsdt_stack_chk (
    // clock and reset
    input wire clk,
    input wire resetn,
    // register port
    input wire [1:0] reg_addr,
    input wire reg_rd,
    input wire [15:0] reg_rdata,
    // command port
    input wire op_start,
    input wire [3:0] op_code,
    input wire [1:0] op_fmt,
    input wire [2:0] op_reg,
    // results
    input wire op_done,
    input wire op_error,
    input wire mem_we,
    input wire [79:0] mem_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // ----------------
    // answer shapes
    // ----------------
    sequence s_taken;
        ##1 (op_done && mem_we && !op_error);
    endsequence
    sequence s_refused;
        ##1 (op_done && op_error && !mem_we);
    endsequence
    sequence s_quiet;
        ##1 (op_done && !op_error && !mem_we);
    endsequence
    // loads write no memory; int fmt 3 left out as undefined
    wire is_load = op_code == `FPSDT_OP_RLD || op_code == `FPSDT_OP_DLD
        || (op_code == `FPSDT_OP_ILD && op_fmt != 2'h3);
    wire go_rst = op_start && op_code == `FPSDT_OP_RST;
    wire go_rstp = op_start && op_code == `FPSDT_OP_RSTP;
    // ----------------
    // properties
    // ----------------
    a_done_follows_start: assert property (op_start |=> op_done)
        else $error("no done after command");
    a_done_has_cause: assert property (op_done |-> $past(op_start))
        else $error("done without command");
    a_write_needs_done: assert property (mem_we |-> op_done)
        else $error("memory write outside done");
    a_out_needs_write: assert property (!$stable(mem_out) |-> mem_we)
        else $error("store result moved without write");
    a_plain_temp_refused: assert property
        (go_rst && op_fmt == `FPSDT_F_TEMP |-> s_refused)
        else $error("plain store took temp destination");
    a_pop_temp_taken: assert property
        (go_rstp && op_fmt == `FPSDT_F_TEMP |-> s_taken)
        else $error("popping store refused temp destination");
    a_pure_pop: assert property
        (go_rstp && op_fmt == `FPSDT_F_REG && op_reg == 3'h0 |-> s_quiet)
        else $error("pop of top moved data");
    a_int_long_refused: assert property
        (op_start && op_code == `FPSDT_OP_IST
        && op_fmt == `FPSDT_F_ILONG |-> s_refused)
        else $error("plain int store took long");
    a_pop_long_taken: assert property
        (op_start && op_code == `FPSDT_OP_ISTP
        && op_fmt == `FPSDT_F_ILONG |-> s_taken)
        else $error("popping int store refused long");
    a_load_no_write: assert property (op_start && is_load |-> s_quiet)
        else $error("load wrote memory");
    a_swap_quiet: assert property
        (op_start && op_code == `FPSDT_OP_SWAP |-> s_quiet)
        else $error("swap wrote memory");
    a_unmapped_zero: assert property
        (reg_rd && reg_addr == 2'h3 |=> reg_rdata == 16'h0)
        else $error("unmapped read not zero");
endmodule

bind fpsdt_stack fpsdt_stack_chk chk_u (
    .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .op_start(op_start), .op_code(op_code),
    .op_fmt(op_fmt), .op_reg(op_reg), .op_done(op_done),
    .op_error(op_error), .mem_we(mem_we), .mem_out(mem_out)
);

// file: tb/fpsdt_host_model.sv
/* host side: presents the memory operand beside each command strobe.
   assumes the bench sets the operand on the edge that raises the strobe. */
module fpsdt_host_model (
    // strobe and operand from the instruction stream
    input wire logic op_start,
    input wire logic [79:0] operand,
    // operand bus into the block
    output logic [79:0] mem_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // bus means nothing off the strobe, so show inverted junk there
    assign mem_in = op_start ? operand : ~operand;
endmodule

// file: tb/fp_stack_data_transfer_tb_top.sv
/* bench top for the stack data-transfer block, one task per scenario.
   assumes the design and its map header are on the include path. */
`include "fpsdt_map.vh"
module fp_stack_data_transfer_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, resetn, reg_wr, reg_rd, op_start, op_reg_given;
    logic [1:0] reg_addr, op_fmt;
    logic [15:0] reg_wdata, reg_rdata;
    logic [3:0] op_code;
    logic [2:0] op_reg;
    logic [79:0] operand, mem_in, mem_out;
    logic op_done, op_error, mem_we;
    int n_errors = 0;
    int check_count = 0;
    fpsdt_stack dut_u (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .op_start(op_start), .op_code(op_code),
        .op_fmt(op_fmt), .op_reg(op_reg), .op_reg_given(op_reg_given),
        .mem_in(mem_in), .op_done(op_done), .op_error(op_error),
        .mem_we(mem_we), .mem_out(mem_out));
    fpsdt_host_model host_u (.op_start(op_start), .operand(operand),
        .mem_in(mem_in));
    // ----------------
    // helpers
    // ----------------
    task automatic chk(input logic [79:0] seen, exp, input string nm);
        check_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [1:0] a, input logic [15:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, e, "reg_rdata");
    endtask
    task automatic st(input logic [15:0] t, g);
        rd(`FPSDT_REG_TOP, t);
        rd(`FPSDT_REG_TAG, g);
    endtask
    // r[3] is the swap's register-given flag
    task automatic op(input logic [3:0] c, input logic [1:0] f,
        input logic [3:0] r, input logic [79:0] m, input logic err, we);
        @(posedge clk);
        op_start <= 1'b1;
        op_code <= c;
        op_fmt <= f;
        op_reg <= r[2:0];
        op_reg_given <= r[3];
        operand <= m;
        @(posedge clk);
        op_start <= 1'b0;
        #1;
        chk(op_done, 1'b1, "op_done");
        chk(op_error, err, "op_error");
        chk(mem_we, we, "mem_we");
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // ----------------
    // scenarios
    // ----------------
    task automatic t_reset();
        wr(`FPSDT_REG_TOP, 16'h0005);
        st(16'h0, 16'hFFFF);
        rd(`FPSDT_REG_CTRL, 16'h0);
        rd(2'h3, 16'h0);
    endtask
    task automatic t_push_pop();
        op(`FPSDT_OP_RLD, `FPSDT_F_SHORT, 0, 80'h3F800000, 0, 0);
        st(16'h7, 16'h3FFF);
        op(`FPSDT_OP_RLD, `FPSDT_F_REG, 0, 0, 0, 0);
        st(16'h6, 16'h0FFF);
        op(`FPSDT_OP_RST, `FPSDT_F_SHORT, 0, 0, 0, 1);
        chk(mem_out[31:0], 32'h3F800000, "dup");
        op(`FPSDT_OP_RST, `FPSDT_F_TEMP, 0, 0, 1, 0);
        op(`FPSDT_OP_RSTP, `FPSDT_F_REG, 0, 0, 0, 0);
        st(16'h7, 16'h3FFF);
        op(`FPSDT_OP_RSTP, `FPSDT_F_TEMP, 0, 0, 0, 1);
        chk(mem_out, 80'h3FFF8000000000000000, "temp");
        st(16'h0, 16'hFFFF);
    endtask
    task automatic t_round();
        logic [31:0] ex [4] = '{32'h3F800000, 32'h3F800000,
            32'h3F800001, 32'h3F800000};
        op(`FPSDT_OP_RLD, `FPSDT_F_LONG, 0, 80'h3FF0000000400000, 0, 0);
        for (int i = 0; i < 4; i++)
        begin
            wr(`FPSDT_REG_CTRL, 16'(i));
            op(`FPSDT_OP_RST, `FPSDT_F_SHORT, 0, 0, 0, 1);
            chk(mem_out[31:0], ex[i], "rounded");
        end
        // source top must survive every rounded store
        op(`FPSDT_OP_RSTP, `FPSDT_F_LONG, 0, 0, 0, 1);
        chk(mem_out[63:0], 64'h3FF0000000400000, "exact");
        wr(`FPSDT_REG_CTRL, 16'h0);
    endtask
    task automatic t_special();
        op(`FPSDT_OP_RLD, `FPSDT_F_LONG, 0, 80'h7FF800001FFFFFFF, 0, 0);
        st(16'h7, 16'hBFFF);
        op(`FPSDT_OP_RSTP, `FPSDT_F_SHORT, 0, 0, 0, 1);
        chk(mem_out[31:0], 32'h7FC00000, "chopped");
        st(16'h0, 16'hFFFF);
    endtask
    task automatic t_int();
        op(`FPSDT_OP_ILD, `FPSDT_F_IWORD, 0, 80'h0, 0, 0);
        st(16'h7, 16'h7FFF);
        op(`FPSDT_OP_ILD, `FPSDT_F_ISHORT, 0, 80'hFFFFFFFB, 0, 0);
        st(16'h6, 16'h4FFF);
        op(`FPSDT_OP_IST, `FPSDT_F_ILONG, 0, 0, 1, 0);
        op(`FPSDT_OP_IST, `FPSDT_F_IWORD, 0, 0, 0, 1);
        chk(mem_out[15:0], 16'hFFFB, "iword");
        op(`FPSDT_OP_ISTP, `FPSDT_F_ILONG, 0, 0, 0, 1);
        chk(mem_out[63:0], 64'hFFFFFFFFFFFFFFFB, "ilong");
        op(`FPSDT_OP_ISTP, `FPSDT_F_IWORD, 0, 0, 0, 1);
        st(16'h0, 16'hFFFF);
        op(`FPSDT_OP_RLD, `FPSDT_F_SHORT, 0, 80'h40200000, 0, 0);
        wr(`FPSDT_REG_CTRL, 16'h2);
        op(`FPSDT_OP_IST, `FPSDT_F_IWORD, 0, 0, 0, 1);
        chk(mem_out[15:0], 16'h0003, "up");
        wr(`FPSDT_REG_CTRL, 16'h0);
        op(`FPSDT_OP_IST, `FPSDT_F_IWORD, 0, 0, 0, 1);
        chk(mem_out[15:0], 16'h0002, "even");
        op(`FPSDT_OP_DSTP, 0, 0, 0, 0, 1);
        chk(mem_out[71:0], 72'h3, "half");
        st(16'h0, 16'hFFFF);
    endtask
    task automatic t_dec();
        op(`FPSDT_OP_DLD, 0, 0, 80'h80000000000000000000, 0, 0);
        st(16'h7, 16'h7FFF);
        op(`FPSDT_OP_IST, `FPSDT_F_IWORD, 0, 0, 0, 1);
        chk(mem_out[15:0], 16'h0000, "negzero");
        op(`FPSDT_OP_RST, `FPSDT_F_SHORT, 0, 0, 0, 1);
        chk(mem_out[31:0], 32'h80000000, "rzero");
        op(`FPSDT_OP_RSTP, `FPSDT_F_TEMP, 0, 0, 0, 1);
        chk(mem_out, 80'h80000000000000000000, "sign");
        op(`FPSDT_OP_DLD, 0, 0, 80'h25, 0, 0);
        op(`FPSDT_OP_ISTP, `FPSDT_F_IWORD, 0, 0, 0, 1);
        chk(mem_out[15:0], 16'h0019, "decimal");
    endtask
    task automatic t_swap();
        op(`FPSDT_OP_RLD, `FPSDT_F_SHORT, 0, 80'h3F800000, 0, 0);
        op(`FPSDT_OP_RLD, `FPSDT_F_SHORT, 0, 80'h40000000, 0, 0);
        op(`FPSDT_OP_SWAP, 0, 4'h3, 0, 0, 0);
        op(`FPSDT_OP_RST, `FPSDT_F_SHORT, 0, 0, 0, 1);
        chk(mem_out[31:0], 32'h3F800000, "swap1");
        op(`FPSDT_OP_SWAP, 0, 4'h9, 0, 0, 0);
        op(`FPSDT_OP_RST, `FPSDT_F_SHORT, 0, 0, 0, 1);
        chk(mem_out[31:0], 32'h40000000, "swap2");
        op(4'h9, 0, 0, 0, 1, 0);
        st(16'h6, 16'h0FFF);
        op(`FPSDT_OP_ISTP, `FPSDT_F_REG, 0, 0, 1, 0);
        // copy top into the register below it, then pop the original
        op(`FPSDT_OP_RST, `FPSDT_F_REG, 4'h1, 0, 0, 0);
        op(`FPSDT_OP_RSTP, `FPSDT_F_SHORT, 0, 0, 0, 1);
        op(`FPSDT_OP_RST, `FPSDT_F_SHORT, 0, 0, 0, 1);
        chk(mem_out[31:0], 32'h40000000, "copy");
        st(16'h7, 16'h3FFF);
    endtask
    // ----------------
    // run control
    // ----------------
    // clock at 125 MHz
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // main sequence
    initial
    begin
        {resetn, reg_wr, reg_rd, op_start, op_reg_given} = '0;
        {reg_addr, op_fmt, reg_wdata, op_code, op_reg, operand} = '0;
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        t_reset();
        t_push_pop();
        t_round();
        t_special();
        t_int();
        t_dec();
        t_swap();
        end_of_test();
    end
    // watchdog: all scenarios need well under a thousand cycles
    initial
    begin
        repeat (5000) @(posedge clk);
        n_errors++;
        end_of_test();
    end
endmodule
